// ===== design/flash_bank_device.sv
// Purpose: Flash command front end for bank select, status and map detect
// Assumes: Serial clock sampled by sys_clk, half period of 4+ cycles
// Notes: Array contents come from the user side through mem_addr/mem_rdata
// Behaviour
// (R1) Bank bit 7 enables four-byte addressing
// (R2) 16h reads bank, 17h writes one byte
// (R3) Three-byte addresses use bank upper bits
// (R4) 13h read always takes four address bytes
// (R5) Resets and power cycle leave four-byte mode
// (R6) Status 1 mixes volatile and nonvolatile bits
// (R7) Status 1 write needs prior 06h
// (R8) 07h returns status register 2
// (R9) 07h has no address, zero latency
// (R10) Host masks status 2 with 80h
// (R11) First descriptor: command type, not last
// (R12) Descriptor bytes FCh 07h 30h 80h at 40h
// (R13) Dword 16 bytes F0h 28h FAh A8h
// (R14) Bit 7 set: four address bytes follow
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module flash_bank_device #(
    parameter logic ERASE_OPT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    spi_link_if.flash link,
    input wire logic [7:0] mem_rdata,
    output logic [31:0] mem_addr,
    output logic mem_rd,
    output logic four_byte_mode,
    output logic [7:0] bank_value,
    output logic [flash_link_pkg::SR1_NV_W-1:0] sr1_nv
);
    import flash_link_pkg::*;

    typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_WRITE, ST_READ, ST_SKIP} dev_state_t;

    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic cs_n_s1_q, cs_n_s2_q;
    logic mosi_s1_q, mosi_s2_q;
    logic [2:0] bit_q;
    logic [6:0] rx_q;
    dev_state_t state_q;
    logic [7:0] cmd_q;
    logic [2:0] cnt_q;
    logic [23:0] addr_q;
    logic [7:0] bank_q;
    logic wel_q;
    logic [5:0] sr1_nv_q;
    logic [31:0] mem_addr_q;
    logic mem_rd_q;
    logic load_q;
    logic [7:0] tx_q;
    logic miso_q;
    logic miso_oe_q;
    logic rise;
    logic fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [31:0] eff_addr;
    logic [7:0] resp;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            cs_n_s1_q <= 1'b1;
            cs_n_s2_q <= 1'b1;
            mosi_s1_q <= 1'b0;
            mosi_s2_q <= 1'b0;
        end
        else
        begin
            sck_s1_q <= link.sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            cs_n_s1_q <= link.cs_n;
            cs_n_s2_q <= cs_n_s1_q;
            mosi_s1_q <= link.mosi;
            mosi_s2_q <= mosi_s1_q;
        end
    end

    assign rise = sck_s2_q & ~sck_s3_q & ~cs_n_s2_q;
    assign fall = ~sck_s2_q & sck_s3_q & ~cs_n_s2_q;
    assign byte_done = rise & (bit_q == 3'h7);
    assign rx_byte = {rx_q, mosi_s2_q};

    // ----------------------------------------
    // Bit shifter
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_q <= 3'h0;
            rx_q <= 7'h00;
        end
        else if (cs_n_s2_q)
        begin
            bit_q <= 3'h0;
        end
        else if (rise)
        begin
            bit_q <= bit_q + 3'h1;
            rx_q <= rx_byte[6:0];
        end
    end

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_OPC;
            cmd_q <= 8'h00;
            cnt_q <= 3'h0;
            addr_q <= 24'h000000;
        end
        else if (cs_n_s2_q)
        begin
            state_q <= ST_OPC;
        end
        else if (byte_done)
        begin
            case (state_q)
                ST_OPC:
                begin
                    cmd_q <= rx_byte;
                    case (rx_byte)
                        OP_READ:
                        begin
                            state_q <= ST_ADDR;
                            // (R14) Mode picks width
                            cnt_q <= bank_q[BANK_EXT_BIT] ? ADDR_BYTES4 : ADDR_BYTES3;
                        end
                        OP_READ4:
                        begin
                            state_q <= ST_ADDR;
                            // (R4) Always four bytes
                            cnt_q <= ADDR_BYTES4;
                        end
                        OP_DISC:
                        begin
                            state_q <= ST_ADDR;
                            cnt_q <= ADDR_BYTES3;
                        end
                        // (R9) No address, no wait
                        OP_BANK_RD, OP_RDSR1, OP_RDSR2: state_q <= ST_READ;
                        OP_BANK_WR: state_q <= ST_WRITE;
                        // (R7) Refused without enable
                        OP_WRSR: state_q <= wel_q ? ST_WRITE : ST_SKIP;
                        default: state_q <= ST_SKIP;
                    endcase
                end
                ST_ADDR:
                begin
                    addr_q <= {addr_q[15:0], rx_byte};
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1)
                    begin
                        state_q <= (cmd_q == OP_DISC) ? ST_DUMMY : ST_READ;
                    end
                end
                ST_DUMMY: state_q <= ST_READ;
                // (R2) Exactly one data byte
                ST_WRITE: state_q <= ST_SKIP;
                default: state_q <= state_q;
            endcase
        end
    end

    // ----------------------------------------
    // Bank, enable latch and status 1
    // ----------------------------------------
    // (R5) Hardware reset and power-up clear
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bank_q <= BANK_RESET;
        end
        else if (byte_done && state_q == ST_OPC && rx_byte == OP_SOFT_RST)
        begin
            // (R5) Software reset clears
            bank_q <= BANK_RESET;
        end
        else if (byte_done && state_q == ST_WRITE && cmd_q == OP_BANK_WR)
        begin
            // (R2) Write takes data
            bank_q <= rx_byte;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wel_q <= 1'b0;
        end
        else if (byte_done && state_q == ST_OPC)
        begin
            // (R7) Enable latch set
            if (rx_byte == OP_WREN)
            begin
                wel_q <= 1'b1;
            end
            else if (rx_byte == OP_WRDI || rx_byte == OP_SOFT_RST)
            begin
                wel_q <= 1'b0;
            end
        end
        else if (byte_done && state_q == ST_WRITE && cmd_q == OP_WRSR)
        begin
            wel_q <= 1'b0;
        end
    end

    // Only a real array would keep these across power loss
    // (R6) Nonvolatile part of status 1
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sr1_nv_q <= SR1_NV_RESET;
        end
        else if (byte_done && state_q == ST_WRITE && cmd_q == OP_WRSR)
        begin
            sr1_nv_q <= rx_byte[7:2];
        end
    end

    // ----------------------------------------
    // Address translation and array pointer
    // ----------------------------------------
    always_comb
    begin
        if (cmd_q == OP_DISC)
        begin
            eff_addr = {8'h00, addr_q[15:0], rx_byte};
        end
        else if (cmd_q == OP_READ4 || bank_q[BANK_EXT_BIT])
        begin
            // (R1) Bank bits ignored
            eff_addr = {addr_q, rx_byte};
        end
        else
        begin
            // (R3) Bank picks segment
            eff_addr = {1'b0, bank_q[6:0], addr_q[15:0], rx_byte};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_addr_q <= 32'h00000000;
        end
        else if (byte_done && state_q == ST_ADDR && cnt_q == 3'h1)
        begin
            mem_addr_q <= eff_addr;
        end
        else if (byte_done && state_q == ST_READ)
        begin
            mem_addr_q <= mem_addr_q + 32'h00000001;
        end
    end

    // ----------------------------------------
    // Response path
    // ----------------------------------------
    always_comb
    begin
        case (cmd_q)
            OP_BANK_RD: resp = bank_q;
            OP_RDSR1: resp = {sr1_nv_q, wel_q, 1'b0};
            // (R8) Map detect returns status 2
            OP_RDSR2: resp = {ERASE_OPT, 7'h00};
            // (R12) Descriptor bytes from table
            // (R11) FCh: command type, more follow
            // (R13) Dword 16 from table
            OP_DISC: resp = disc_byte(mem_addr_q[7:0]);
            default: resp = mem_rdata;
        endcase
    end

    // Load one cycle late so the pointer has settled
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            load_q <= 1'b0;
            mem_rd_q <= 1'b0;
        end
        else
        begin
            load_q <= byte_done;
            mem_rd_q <= load_q && state_q == ST_READ && (cmd_q == OP_READ || cmd_q == OP_READ4);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_q <= 8'h00;
            miso_q <= 1'b1;
            miso_oe_q <= 1'b0;
        end
        else if (cs_n_s2_q)
        begin
            miso_oe_q <= 1'b0;
            miso_q <= 1'b1;
        end
        else if (load_q && state_q == ST_READ)
        begin
            tx_q <= resp;
        end
        else if (fall)
        begin
            miso_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            miso_oe_q <= (state_q == ST_READ);
        end
    end

    assign link.miso_o = miso_q;
    assign link.miso_oe = miso_oe_q;
    assign mem_addr = mem_addr_q;
    assign mem_rd = mem_rd_q;
    assign four_byte_mode = bank_q[BANK_EXT_BIT];
    assign bank_value = bank_q;
    assign sr1_nv = sr1_nv_q;

endmodule // flash_bank_device
`default_nettype wire

// ===== design/flash_bank_host.sv
// Purpose: Serial flash host driven from a small register port
// Assumes: Device samples the link with a two-stage synchroniser
// Notes: HALF sets the serial clock half period in sys_clk cycles
`timescale 1ns/100ps
`default_nettype none
module flash_bank_host #(
    parameter int HALF = flash_link_pkg::HALF_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rstn,
    spi_link_if.host link,
    input wire logic [flash_link_pkg::REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import flash_link_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} host_state_t;

    host_state_t state_q;
    logic [7:0] opc_q;
    logic [2:0] len_q;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] rx_q;
    logic mode_q;
    logic smap_q;
    logic pre_q;
    logic [7:0] cur_q;
    logic [3:0] idx_q;
    logic [2:0] bit_q;
    logic [15:0] tick_q;
    logic sck_q;
    logic cs_n_q;
    logic mosi_q;
    logic [7:0] txb_q;
    logic [31:0] rdata_q;
    logic miso_s1_q;
    logic miso_s2_q;
    logic [3:0] naddr;
    logic [3:0] ndum;
    logic [3:0] nlen;
    logic [3:0] last_idx;
    logic [3:0] nidx;
    logic [3:0] k;
    logic [7:0] nxt;
    logic [7:0] first;
    logic start;

    localparam logic [15:0] HALF_M1 = 16'(HALF - 1);

    // ----------------------------------------
    // Frame shape from the current opcode
    // ----------------------------------------
    always_comb
    begin
        naddr = 4'h0;
        ndum = 4'h0;
        nlen = {1'b0, len_q};
        case (cur_q)
            // (R14) Track device width
            OP_READ: naddr = mode_q ? {1'b0, ADDR_BYTES4} : {1'b0, ADDR_BYTES3};
            OP_READ4: naddr = {1'b0, ADDR_BYTES4};
            OP_DISC:
            begin
                naddr = {1'b0, ADDR_BYTES3};
                ndum = 4'h1;
            end
            // (R2) One byte only
            OP_BANK_WR: nlen = 4'h1;
            OP_WREN, OP_SOFT_RST: nlen = 4'h0;
            default: nlen = {1'b0, len_q};
        endcase
        last_idx = naddr + ndum + nlen;
        nidx = idx_q + 4'h1;
        k = nidx - naddr - ndum - 4'h1;
        if (nidx <= naddr)
        begin
            nxt = addr_q[8 * (naddr - nidx) +: 8];
        end
        else if (nidx <= naddr + ndum)
        begin
            nxt = 8'h00;
        end
        else
        begin
            nxt = wdata_q[8 * k[1:0] +: 8];
        end
    end

    assign start = (state_q == H_IDLE) && reg_wr && (reg_addr == REG_CTRL);
    // (R7) Status 1 write preceded by enable
    assign first = (reg_wdata[7:0] == OP_WRSR) ? OP_WREN : reg_wdata[7:0];

    // ----------------------------------------
    // Command registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            opc_q <= 8'h00;
            len_q <= 3'h0;
            addr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
        end
        else if (state_q == H_IDLE && reg_wr)
        begin
            case (reg_addr)
                REG_CTRL:
                begin
                    opc_q <= reg_wdata[7:0];
                    len_q <= reg_wdata[CTRL_LEN_LSB +: 3];
                end
                REG_WDATA: wdata_q <= reg_wdata;
                REG_ADDR: addr_q <= reg_wdata;
                default: opc_q <= opc_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_q <= 32'h00000000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                REG_CTRL: rdata_q <= {21'h000000, len_q, opc_q};
                REG_WDATA: rdata_q <= wdata_q;
                REG_RDATA: rdata_q <= rx_q;
                REG_STATUS: rdata_q <= {29'h00000000, smap_q, mode_q, state_q != H_IDLE};
                REG_ADDR: rdata_q <= addr_q;
                default: rdata_q <= 32'h00000000;
            endcase
        end
        else
        begin
            rdata_q <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // Serial engine
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            miso_s1_q <= 1'b1;
            miso_s2_q <= 1'b1;
        end
        else
        begin
            miso_s1_q <= link.miso;
            miso_s2_q <= miso_s1_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= H_IDLE;
            pre_q <= 1'b0;
            cur_q <= 8'h00;
            idx_q <= 4'h0;
            bit_q <= 3'h0;
            tick_q <= 16'h0000;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            mosi_q <= 1'b0;
            txb_q <= 8'h00;
            rx_q <= 32'h00000000;
            mode_q <= 1'b0;
            smap_q <= 1'b0;
        end
        else if (start || (state_q == H_GAP && tick_q == 16'h0000 && pre_q))
        begin
            state_q <= H_RUN;
            pre_q <= start && (reg_wdata[7:0] == OP_WRSR);
            cur_q <= start ? first : opc_q;
            txb_q <= start ? first : opc_q;
            mosi_q <= start ? first[7] : opc_q[7];
            cs_n_q <= 1'b0;
            sck_q <= 1'b0;
            idx_q <= 4'h0;
            bit_q <= 3'h0;
            tick_q <= HALF_M1;
        end
        else if (state_q == H_GAP && tick_q == 16'h0000)
        begin
            state_q <= H_IDLE;
        end
        else if (state_q != H_IDLE && tick_q != 16'h0000)
        begin
            tick_q <= tick_q - 16'h0001;
        end
        else if (state_q == H_RUN && !sck_q)
        begin
            tick_q <= HALF_M1;
            sck_q <= 1'b1;
            rx_q <= {rx_q[30:0], miso_s2_q};
        end
        else if (state_q == H_RUN)
        begin
            tick_q <= HALF_M1;
            sck_q <= 1'b0;
            bit_q <= bit_q + 3'h1;
            if (bit_q != 3'h7)
            begin
                txb_q <= {txb_q[6:0], 1'b0};
                mosi_q <= txb_q[6];
            end
            else if (idx_q != last_idx)
            begin
                idx_q <= nidx;
                txb_q <= nxt;
                mosi_q <= nxt[7];
            end
            else
            begin
                cs_n_q <= 1'b1;
                mosi_q <= 1'b0;
                state_q <= H_GAP;
                if (cur_q == OP_BANK_WR)
                begin
                    mode_q <= wdata_q[BANK_EXT_BIT];
                end
                else if (cur_q == OP_SOFT_RST)
                begin
                    mode_q <= 1'b0;
                end
                else if (cur_q == OP_RDSR2)
                begin
                    // (R10) Masked option bit
                    smap_q <= (rx_q[7:0] & SMAP_MASK) != 8'h00;
                end
            end
        end
    end

    assign link.sck = sck_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = mosi_q;
    assign reg_rdata = rdata_q;

endmodule // flash_bank_host
`default_nettype wire

// ===== design/flash_link_pkg.sv
// Purpose: Shared constants for the serial flash bank/map-detect link
// Assumes: One system clock; the host derives the serial clock from it
// Notes: Opcodes, field positions, reset values and discovery bytes
package flash_link_pkg;

    // ----------------------------------------
    // Instruction codes
    // ----------------------------------------
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_RDSR2 = 8'h07;
    localparam logic [7:0] OP_READ4 = 8'h13;
    localparam logic [7:0] OP_BANK_RD = 8'h16;
    localparam logic [7:0] OP_BANK_WR = 8'h17;
    localparam logic [7:0] OP_DISC = 8'h5a;
    localparam logic [7:0] OP_SOFT_RST = 8'hf0;

    // ----------------------------------------
    // Device register layout
    // ----------------------------------------
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam int BANK_EXT_BIT = 7;
    localparam int SR1_NV_W = 6;
    localparam logic [5:0] SR1_NV_RESET = 6'h00;
    localparam logic [7:0] SMAP_MASK = 8'h80;
    localparam logic [2:0] ADDR_BYTES3 = 3'h3;
    localparam logic [2:0] ADDR_BYTES4 = 3'h4;

    // ----------------------------------------
    // Host command port map and timing
    // ----------------------------------------
    localparam int REG_AW = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_WDATA = 5'h04;
    localparam logic [4:0] REG_RDATA = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0c;
    localparam logic [4:0] REG_ADDR = 5'h10;
    localparam int CTRL_LEN_LSB = 8;
    localparam int HALF_DEFAULT = 8;

    // ----------------------------------------
    // Discovery data
    // ----------------------------------------
    function automatic logic [7:0] disc_byte(input logic [7:0] off);
        case (off)
            8'h3c: disc_byte = 8'hf0;
            8'h3d: disc_byte = 8'h28;
            8'h3e: disc_byte = 8'hfa;
            8'h3f: disc_byte = 8'ha8;
            8'h40: disc_byte = 8'hfc;
            8'h41: disc_byte = 8'h07;
            8'h42: disc_byte = 8'h30;
            8'h43: disc_byte = 8'h80;
            default: disc_byte = 8'hff;
        endcase
    endfunction

endpackage

// ===== design/spi_link_if.sv
// Purpose: Serial link between flash host and flash device
// Assumes: Host drives clock, select and data out; device drives data back
// Notes: Returned line idles high whenever the device does not drive it
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;

    assign miso = miso_oe ? miso_o : 1'b1;

    modport host (
        output sck,
        output cs_n,
        output mosi,
        input miso
    );

    modport flash (
        input sck,
        input cs_n,
        input mosi,
        output miso_o,
        output miso_oe
    );
endinterface
`default_nettype wire

// ===== dv/flash_link_monitor.sv
// Purpose: Wire checks on the host-to-device serial link
// Assumes: Host serial clock half period of 8 sys_clk cycles
// Notes: Register contents are judged by the bench, not here
`timescale 1ns/100ps
`default_nettype none
module flash_link_monitor (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Frame steps
    // ----------------------------------------
    sequence s_open;
        $fell(cs_n);
    endsequence
    sequence s_close;
        $rose(cs_n);
    endsequence

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_open_sck_low: assert property (s_open |-> !sck [*6])
        else $error("sck moved too soon after select");
    chk_sck_high_len: assert property ($rose(sck) |-> sck [*7] ##[1:2] !sck)
        else $error("sck high phase wrong length");
    chk_frame_gap: assert property (s_close |-> cs_n [*4])
        else $error("select gap too short");
    chk_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("mosi moved while sck high");
    chk_miso_hold: assert property (miso_oe && sck && $past(sck) |-> $stable(miso_o))
        else $error("miso moved while sck high");
    chk_oe_release: assert property (s_close |-> ##[1:5] !miso_oe)
        else $error("miso not released after frame");
    chk_oe_deselect: assert property (cs_n [*6] |-> !miso_oe)
        else $error("miso driven while deselected");
    // Data may only start in the low phase
    chk_oe_sck_low: assert property ($rose(miso_oe) |-> !sck)
        else $error("miso enabled during sck high");
    // Undriven return line must read as the pull-up level
    chk_miso_idle: assert property (!miso_oe |-> miso)
        else $error("miso not high while released");
    chk_miso_follow: assert property (miso_oe |-> miso == miso_o)
        else $error("miso differs from driven value");
endmodule // flash_link_monitor
`default_nettype wire

// ===== dv/tb_flash_addr_bank_and_map_detect.sv
// Purpose: Self-checking bench, host and device joined by one link
// Assumes: Default host timing; array byte is the top address byte
// Notes: Status write refusal cannot be forced, host always sends 06h
`timescale 1ns/100ps
`default_nettype none
module tb_flash_addr_bank_and_map_detect;
    import flash_link_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, mem_addr, rd, st;
    logic [7:0] bank_value;
    logic [5:0] sr1_nv;
    logic four_byte_mode;
    int n_errors = 0;
    int num_checks = 0;

    spi_link_if link();
    flash_bank_device #(.ERASE_OPT(1'b1)) i_flash_bank_device (.sys_clk(sys_clk),
        .rstn(rstn), .link(link), .mem_rdata(mem_addr[31:24]), .mem_addr(mem_addr),
        .mem_rd(), .four_byte_mode(four_byte_mode), .bank_value(bank_value),
        .sr1_nv(sr1_nv));
    flash_bank_host #(.HALF(8)) i_flash_bank_host (.sys_clk(sys_clk), .rstn(rstn),
        .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    flash_link_monitor i_flash_link_monitor (.sys_clk(sys_clk), .rstn(rstn),
        .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o),
        .miso_oe(link.miso_oe), .miso(link.miso));

    always #5 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One strobe cycle; read data lands in rd
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic run(input logic [7:0] op, input logic [2:0] n, input logic [31:0] d,
        input logic [31:0] a);
        int i;
        bus(1'b1, REG_WDATA, d);
        bus(1'b1, REG_ADDR, a);
        bus(1'b1, REG_CTRL, {21'h0, n, op});
        for (i = 0; i < 2000; i++)
        begin
            bus(1'b0, REG_STATUS, '0);
            if (rd[0] === 1'b0)
                break;
        end
        st = rd;
        if (i == 2000)
        begin
            n_errors++;
            print_verdict();
        end
        bus(1'b0, REG_RDATA, '0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_bank();
        run(OP_BANK_WR, 3'h1, 32'h80, 32'h0);
        check("four_byte_mode", 32'h1, 32'(four_byte_mode));
        check("host_mode", 32'h1, 32'(st[1]));
        run(OP_BANK_RD, 3'h1, 32'h0, 32'h0);
        check("bank_read", 32'h80, rd & 32'hff);
        run(OP_READ, 3'h1, 32'h0, 32'h7f00_0000);
        check("wide_read", 32'h7f, rd & 32'hff);
        run(OP_BANK_WR, 3'h1, 32'h05, 32'h0);
        run(OP_READ, 3'h1, 32'h0, 32'h12_3456);
        check("banked_read", 32'h05, rd & 32'hff);
        run(OP_READ4, 3'h1, 32'h0, 32'h3a00_0000);
        check("read4", 32'h3a, rd & 32'hff);
        $display("test bank done");
    endtask

    task automatic t_reset();
        run(OP_BANK_WR, 3'h1, 32'h80, 32'h0);
        run(OP_SOFT_RST, 3'h0, 32'h0, 32'h0);
        check("soft_mode", 32'h0, 32'(four_byte_mode));
        run(OP_BANK_WR, 3'h1, 32'h80, 32'h0);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        #1 check("hard_bank", 32'h0, 32'(bank_value));
        $display("test reset done");
    endtask

    task automatic t_status();
        run(OP_WRSR, 3'h1, 32'hfc, 32'h0);
        check("sr1_nv", 32'h3f, 32'(sr1_nv));
        run(OP_RDSR1, 3'h1, 32'h0, 32'h0);
        check("sr1_read", 32'hfc, rd & 32'hff);
        $display("test status done");
    endtask

    task automatic t_detect();
        run(OP_RDSR2, 3'h1, 32'h0, 32'h0);
        check("sr2_read", 32'h80, rd & 32'hff);
        check("map_option", 32'h1, 32'(st[2]));
        run(OP_DISC, 3'h4, 32'h0, 32'h3c);
        check("dword16", 32'hf028_faa8, rd);
        run(OP_DISC, 3'h4, 32'h0, 32'h40);
        check("detect1", 32'hfc07_3080, rd);
        check("desc_flags", 32'h0, 32'(rd[25:24]));
        $display("test detect done");
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        t_bank();
        t_reset();
        t_status();
        t_detect();
        print_verdict();
    end
endmodule // tb_flash_addr_bank_and_map_detect
`default_nettype wire
